/* src/dmia_top.sv */
// dmia_top: data memory with three indirect ports and five pointer registers, APB slave.
// assumes: APB master per protocol; paddr[12:2] is the data memory index, bits above 12 unmapped.
//
// Behaviour
// - indirect port locations have no storage; they only steer accesses elsewhere.
// - access to an indirect port acts on the location its pointer addresses.
// - first indirect port uses the single-byte pointer, always within sector 0.
// - second indirect port targets pointer_a_sector:pointer_a_low, any sector.
// - third indirect port targets pointer_b_sector:pointer_b_low, any sector.
// - target that is itself an indirect port: read gives nothing, no second redirection.
// - five pointers are real storage, readable and writable like ordinary locations.
// - paired pointers: high byte selects sector, low byte gives offset in sector.
// - every sector is directly addressable regardless of pointer contents.
// - full address is sector in upper bits, offset in low eight bits.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dmia_top
    import dmia_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    output var  logic [10:0] last_target
);
    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------
    // true for the three storage-less port locations
    function automatic logic is_port(input logic [10:0] a);
        return (a == DMIA_LOC_IND_S0) || (a == DMIA_LOC_IND_A) || (a == DMIA_LOC_IND_B);
    endfunction

    // true for the five pointer locations
    function automatic logic is_ptr(input logic [10:0] a);
        return (a == DMIA_LOC_PTR_S0) || (a == DMIA_LOC_PTR_AL) || (a == DMIA_LOC_PTR_AS)
            || (a == DMIA_LOC_PTR_BL) || (a == DMIA_LOC_PTR_BS);
    endfunction

    // join a sector byte and an offset byte into a full address
    function automatic logic [10:0] full_addr(input logic [7:0] sec, input logic [7:0] off);
        return {sec[DMIA_SEC_W-1:0], off};
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    dmia_state_t  state_r;
    dmia_state_t  state_nxt;
    logic [7:0]   ptr_s0_r;
    logic [7:0]   ptr_s0_nxt;
    logic [7:0]   ptr_al_r;
    logic [7:0]   ptr_al_nxt;
    logic [7:0]   ptr_as_r;
    logic [7:0]   ptr_as_nxt;
    logic [7:0]   ptr_bl_r;
    logic [7:0]   ptr_bl_nxt;
    logic [7:0]   ptr_bs_r;
    logic [7:0]   ptr_bs_nxt;
    logic [31:0]  prdata_r;
    logic [31:0]  prdata_nxt;
    logic         pready_r;
    logic         pready_nxt;
    logic         pslverr_r;
    logic         pslverr_nxt;
    logic [10:0]  last_target_r;
    logic [10:0]  last_target_nxt;

    // ------------------------------------------------------------------
    // address resolution
    // ------------------------------------------------------------------
    logic [10:0]  idx;
    logic         oob;
    logic         setup;
    logic         commit;
    logic [10:0]  target;
    logic         dead;
    logic [7:0]   rd_byte;

    dmia_mem_if   mem_bus ();

    assign idx   = paddr[DMIA_IDX_MSB:DMIA_IDX_LSB];
    assign oob   = |paddr[31:DMIA_OOB_LSB];
    assign setup = psel && !penable;
    // writes happen only with pready high at the edge; read data is captured at setup
    assign commit = psel && penable && pready_r && (state_r == DMIA_ST_RESP);

    // ports redirect once; any other index addresses memory directly
    always_comb begin
        unique case (idx)
            DMIA_LOC_IND_S0: target = {3'b000, ptr_s0_r};
            DMIA_LOC_IND_A:  target = full_addr(ptr_as_r, ptr_al_r);
            DMIA_LOC_IND_B:  target = full_addr(ptr_bs_r, ptr_bl_r);
            default:         target = idx;
        endcase
    end

    // a port reached through a port is a dead end, not a second hop
    assign dead = is_port(idx) && is_port(target);

    // read value of the resolved location
    always_comb begin
        if (dead || is_port(target)) begin
            rd_byte = DMIA_DEAD_READ;
        end else begin
            unique case (target)
                DMIA_LOC_PTR_S0: rd_byte = ptr_s0_r;
                DMIA_LOC_PTR_AL: rd_byte = ptr_al_r;
                DMIA_LOC_PTR_AS: rd_byte = ptr_as_r;
                DMIA_LOC_PTR_BL: rd_byte = ptr_bl_r;
                DMIA_LOC_PTR_BS: rd_byte = ptr_bs_r;
                default:         rd_byte = mem_bus.rdata;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // memory port
    // ------------------------------------------------------------------
    // pointers and ports never reach the array, so their array words stay unused
    assign mem_bus.addr  = target;
    assign mem_bus.wdata = pwdata[7:0];
    assign mem_bus.we    = commit && pwrite && pstrb[0] && !oob && !dead
                        && !is_port(target) && !is_ptr(target);

    dmia_mem u_mem (
        .pclk (pclk),
        .bus  (mem_bus)
    );

    // ------------------------------------------------------------------
    // handshake: fixed one wait-free access, same for direct and indirect
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt  = state_r;
        pready_nxt = 1'b0;
        unique case (state_r)
            DMIA_ST_IDLE: begin
                if (setup) begin
                    state_nxt  = DMIA_ST_RESP;
                    pready_nxt = 1'b1;
                end
            end
            DMIA_ST_RESP: begin
                // access phase always ends at this edge
                state_nxt = DMIA_ST_IDLE;
            end
        endcase
    end

    // read data and error captured in setup, held through the access phase
    always_comb begin
        prdata_nxt      = prdata_r;
        pslverr_nxt     = pslverr_r;
        last_target_nxt = last_target_r;
        if (setup && (state_r == DMIA_ST_IDLE)) begin
            pslverr_nxt = oob;
            prdata_nxt  = (pwrite || oob) ? DMIA_RDATA_RST : {24'h00_0000, rd_byte};
            if (!oob) begin
                last_target_nxt = target;
            end
        end
    end

    // pointer storage, written directly or through a port
    always_comb begin
        ptr_s0_nxt = ptr_s0_r;
        ptr_al_nxt = ptr_al_r;
        ptr_as_nxt = ptr_as_r;
        ptr_bl_nxt = ptr_bl_r;
        ptr_bs_nxt = ptr_bs_r;
        if (commit && pwrite && pstrb[0] && !oob && !dead) begin
            unique case (target)
                DMIA_LOC_PTR_S0: ptr_s0_nxt = pwdata[7:0];
                DMIA_LOC_PTR_AL: ptr_al_nxt = pwdata[7:0];
                DMIA_LOC_PTR_AS: ptr_as_nxt = pwdata[7:0];
                DMIA_LOC_PTR_BL: ptr_bl_nxt = pwdata[7:0];
                DMIA_LOC_PTR_BS: ptr_bs_nxt = pwdata[7:0];
                default: begin
                    // memory or a port: no pointer changes
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r       <= DMIA_ST_IDLE;
            ptr_s0_r      <= DMIA_PTR_RST;
            ptr_al_r      <= DMIA_PTR_RST;
            ptr_as_r      <= DMIA_PTR_RST;
            ptr_bl_r      <= DMIA_PTR_RST;
            ptr_bs_r      <= DMIA_PTR_RST;
            prdata_r      <= DMIA_RDATA_RST;
            pready_r      <= 1'b0;
            pslverr_r     <= 1'b0;
            last_target_r <= 11'h000;
        end else begin
            state_r       <= state_nxt;
            ptr_s0_r      <= ptr_s0_nxt;
            ptr_al_r      <= ptr_al_nxt;
            ptr_as_r      <= ptr_as_nxt;
            ptr_bl_r      <= ptr_bl_nxt;
            ptr_bs_r      <= ptr_bs_nxt;
            prdata_r      <= prdata_nxt;
            pready_r      <= pready_nxt;
            pslverr_r     <= pslverr_nxt;
            last_target_r <= last_target_nxt;
        end
    end

    // outputs straight from flops
    assign prdata      = prdata_r;
    assign pready      = pready_r;
    assign pslverr     = pslverr_r;
    assign last_target = last_target_r;
endmodule
`default_nettype wire

/* src/dmia_pkg.sv */
// dmia_pkg: constants shared by the indirect-addressing data memory block.
// assumes: 2048 x 8 data memory in eight 256-byte sectors; APB word per byte location.
package dmia_pkg;
    // ------------------------------------------------------------------
    // data memory geometry
    // ------------------------------------------------------------------
    localparam int unsigned DMIA_AW      = 11;  // full address: sector[10:8], offset[7:0]
    localparam int unsigned DMIA_DW      = 8;
    localparam int unsigned DMIA_DEPTH   = 2048;
    localparam int unsigned DMIA_SEC_W   = 3;   // sector bits actually decoded
    localparam int unsigned DMIA_OFF_W   = 8;

    // ------------------------------------------------------------------
    // special locations (data memory index; APB byte address = 4 * index)
    // ------------------------------------------------------------------
    localparam logic [10:0] DMIA_LOC_IND_S0  = 11'h000; // indirect_port_sector0
    localparam logic [10:0] DMIA_LOC_PTR_S0  = 11'h001; // pointer_sector0
    localparam logic [10:0] DMIA_LOC_IND_A   = 11'h002; // indirect_port_a
    localparam logic [10:0] DMIA_LOC_PTR_AL  = 11'h003; // pointer_a_low
    localparam logic [10:0] DMIA_LOC_PTR_AS  = 11'h004; // pointer_a_sector
    localparam logic [10:0] DMIA_LOC_IND_B   = 11'h005; // indirect_port_b
    localparam logic [10:0] DMIA_LOC_PTR_BL  = 11'h006; // pointer_b_low
    localparam logic [10:0] DMIA_LOC_PTR_BS  = 11'h007; // pointer_b_sector

    // ------------------------------------------------------------------
    // apb address fields and reset values
    // ------------------------------------------------------------------
    localparam int unsigned DMIA_IDX_LSB  = 2;
    localparam int unsigned DMIA_IDX_MSB  = 12;
    localparam int unsigned DMIA_OOB_LSB  = 13;
    localparam logic [7:0]  DMIA_PTR_RST  = 8'h00;
    localparam logic [31:0] DMIA_RDATA_RST = 32'h0000_0000;
    localparam logic [7:0]  DMIA_DEAD_READ = 8'h00;     // value of a read with no effect

    // bus handshake phase, one-hot
    typedef enum logic [1:0] {
        DMIA_ST_IDLE = 2'b01,
        DMIA_ST_RESP = 2'b10
    } dmia_state_t;
endpackage

/* src/dmia_mem_if.sv */
// dmia_mem_if: port bundle between address resolver and data memory array.
// assumes: single clock; memory read is combinational, write is clocked.
`timescale 1ns/1ps
`default_nettype none
interface dmia_mem_if;
    logic [10:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic [7:0]  rdata;

    modport core (output addr, output wdata, output we, input rdata);
    modport mem  (input addr, input wdata, input we, output rdata);
endinterface
`default_nettype wire

/* src/dmia_mem.sv */
// dmia_mem: 2048 x 8 data memory array, async read, write on rising edge.
// assumes: the resolver never writes the indirect or pointer locations here.
`timescale 1ns/1ps
`default_nettype none
module dmia_mem
    import dmia_pkg::*;
(
    input  wire logic pclk,
    dmia_mem_if.mem   bus
);
    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    // no reset on the array: contents are undefined after power-up
    logic [DMIA_DW-1:0] mem_r [DMIA_DEPTH];

    // write port
    always_ff @(posedge pclk) begin
        if (bus.we) begin
            mem_r[bus.addr] <= bus.wdata;
        end
    end

    // read port, used in the apb setup cycle
    assign bus.rdata = mem_r[bus.addr];
endmodule
`default_nettype wire

/* testbench/dmia_top_asserts.sv */
// dmia_top_asserts: port-level timing and steering checks for dmia_top.
// assumes: sees only the top ports; bound below its endmodule.
`timescale 1ns/1ps
`default_nettype none
module dmia_top_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [10:0] last_target
);
    // ------------------------------------------------------------
    // decode of the request seen at a setup edge
    // ------------------------------------------------------------
    logic       setup;
    logic       oob;
    logic       port;
    logic [10:0] idx;
    assign setup = psel & ~penable;
    assign oob   = |paddr[31:13];
    assign idx   = paddr[12:2];
    assign port  = (idx == 11'h000) | (idx == 11'h002) | (idx == 11'h005);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    AST_READY_NEXT: assert property (setup |=> pready)
        else $error("no ready after setup");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_READY_CAUSE: assert property (pready |-> $past(setup))
        else $error("ready without setup");
    AST_ERR_SET: assert property (setup && oob |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_ERR_CLR: assert property (setup && !oob |=> !pslverr)
        else $error("error on mapped access");
    AST_WR_ZERO: assert property (setup && pwrite |=> prdata == 32'h0)
        else $error("read data on a write");
    AST_UPPER: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    AST_DIRECT: assert property (setup && !oob && !port |=> last_target == $past(idx))
        else $error("direct access moved");
    AST_S0: assert property (setup && !oob && idx == 11'h000 |=> last_target[10:8] == 3'h0)
        else $error("port sector0 left sector 0");
    // prdata and last_target only move on the edge after a setup
    AST_HOLD: assert property (!$past(setup) |-> $stable(prdata) && $stable(last_target))
        else $error("outputs changed without request");

    cover property (setup && oob);
    cover property (setup && port && pwrite);
    cover property (setup && port && !pwrite);
endmodule

bind dmia_top dmia_top_asserts u_asserts (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .last_target(last_target));
`default_nettype wire

/* testbench/dmia_cpu_model.sv */
// dmia_cpu_model: apb master standing in for the core datapath.
// assumes: free-running pclk; caller waits out reset before the first call.
`timescale 1ns/1ps
`default_nettype none
module dmia_cpu_model (
    input  wire logic        pclk,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [31:0] paddr,
    output var  logic [31:0] pwdata,
    output var  logic [3:0]  pstrb,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;

    // ------------------------------------------------------------
    // one transfer; released buses get inverted so stale use shows
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d,
                        input logic [3:0] s, output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~{24'h0, d};
    endtask
endmodule
`default_nettype wire

/* testbench/data_memory_indirect_addressing_tb.sv */
// data_memory_indirect_addressing_tb: table-driven check of the indirect ports.
// assumes: dmia_top with bound checker; cpu model drives the apb side.
`timescale 1ns/1ps
`default_nettype none
module data_memory_indirect_addressing_tb;
    import dmia_pkg::*;
    typedef struct { logic w; logic [10:0] idx; logic [7:0] d, exp; logic [10:0] tgt; } dmia_row_t;

    logic        pclk;
    logic        presetn;
    logic        psel, penable, pwrite, pready, pslverr, e;
    logic [31:0] paddr, pwdata, prdata, r;
    logic [3:0]  pstrb;
    logic [10:0] last_target;
    int          bad_count;
    int          cmp_count;
    // ops in order: pointer setup, port use, direct readback, port-to-port
    dmia_row_t rows [18] = '{
        '{1, 11'h001, 8'h40, 8'h00, 11'h001}, '{1, 11'h000, 8'h5a, 8'h00, 11'h040},
        '{0, 11'h040, 8'h00, 8'h5a, 11'h040}, '{0, 11'h001, 8'h00, 8'h40, 11'h001},
        '{1, 11'h004, 8'h01, 8'h00, 11'h004}, '{1, 11'h003, 8'hf0, 8'h00, 11'h003},
        '{1, 11'h002, 8'ha5, 8'h00, 11'h1f0}, '{0, 11'h1f0, 8'h00, 8'ha5, 11'h1f0},
        '{1, 11'h007, 8'h0f, 8'h00, 11'h007}, '{1, 11'h006, 8'h33, 8'h00, 11'h006},
        '{1, 11'h005, 8'h3c, 8'h00, 11'h733}, '{0, 11'h733, 8'h00, 8'h3c, 11'h733},
        '{0, 11'h007, 8'h00, 8'h0f, 11'h007}, '{0, 11'h005, 8'h00, 8'h3c, 11'h733},
        '{1, 11'h001, 8'h02, 8'h00, 11'h001}, '{0, 11'h000, 8'h00, 8'h00, 11'h002},
        '{1, 11'h000, 8'h77, 8'h00, 11'h002}, '{0, 11'h002, 8'h00, 8'ha5, 11'h1f0}};

    dmia_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .last_target(last_target));
    dmia_cpu_model u_cpu (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // ------------------------------------------------------------
    // clock, compare, verdict, watchdog
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic end_of_test();
        if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // a full run needs well under 300 cycles
    initial begin
        repeat (5000) @(posedge pclk);
        bad_count++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        bad_count = 0;
        cmp_count = 0;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        foreach (rows[i]) begin
            u_cpu.xfer(rows[i].w, {19'h0, rows[i].idx, 2'b00}, rows[i].d, 4'hf, r, e);
            chk("rdata", r, {24'h0, rows[i].exp});
            chk("target", {21'h0, last_target}, {21'h0, rows[i].tgt});
        end
        // strobe low: write must not land
        u_cpu.xfer(1'b1, 32'h0000_07c0, 8'h11, 4'he, r, e);
        u_cpu.xfer(1'b0, 32'h0000_07c0, 8'h00, 4'hf, r, e);
        chk("strobe", r, 32'h0000_00a5);
        // unmapped upper address bits
        u_cpu.xfer(1'b0, 32'h0000_2100, 8'h00, 4'hf, r, e);
        chk("err", {31'h0, e}, 32'h1);
        chk("errdata", r, 32'h0);
        // reset in mid-run clears outputs and pointers
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        chk("rst", {prdata[7:0], 11'h000, pready, pslverr, last_target}, 32'h0);
        presetn <= 1'b1;
        u_cpu.xfer(1'b0, 32'h0000_0004, 8'h00, 4'hf, r, e);
        chk("ptr_rst", r, 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
